// ===== bench/clst_host_model.sv
`timescale 1ns/1ps
module clst_host_model (
	input wire logic clk_sys_i,
	input wire logic [9:0] goal_i,
	input wire logic slow_i,
	output logic [9:0] speed_command_o
);
	initial speed_command_o = 10'h000;
	always @(posedge clk_sys_i) begin
		if (!slow_i || speed_command_o == goal_i) begin
			speed_command_o <= (goal_i > 10'h200) ? 10'h200 : goal_i;
		end else if (speed_command_o < goal_i) begin
			speed_command_o <= speed_command_o + 10'h001;
		end else begin
			speed_command_o <= speed_command_o - 10'h001;
		end
	end
endmodule

// ===== bench/clst_top_assertions.sv
`timescale 1ns/1ps
module clst_top_chk #(
	parameter int unsigned DECEL_PERIOD = clst_pkg::DECEL_PERIOD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [clst_pkg::CMD_W-1:0] speed_command_i,
	input wire clst_pkg::clst_reg_req_t reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [clst_pkg::TGT_W-1:0] target_rpm_o,
	input wire logic closed_loop_o,
	input wire logic bypass_o,
	input wire logic [clst_pkg::CMD_W-1:0] bypass_duty_o
);
	import clst_pkg::*;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	a_duty_idle: assert property (
		!bypass_o |-> bypass_duty_o == 10'h000) else $error("duty without bypass");
	a_open_quiet: assert property (
		!closed_loop_o |-> !bypass_o) else $error("bypass in open loop");
	a_duty_source: assert property (
		bypass_o && $past(ce_i) |-> bypass_duty_o == $past(speed_command_i)
		|| bypass_duty_o == CMD_FULL) else $error("bypass duty source");
	a_read_hold: assert property (
		$past(rst_n_i) && !($past(reg_req_i.re) && $past(ce_i)) |-> $stable(reg_rdata_o))
		else $error("read data moved");
	a_unmapped_zero: assert property (
		ce_i && reg_req_i.re && !(reg_req_i.addr inside {[8'h02:8'h0B], 8'h12, [8'h20:8'h23]})
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_tgt_low: assert property (
		ce_i && reg_req_i.re && reg_req_i.addr == ADDR_TGT_L
		|=> {10'h000, reg_rdata_o} == ($past(target_rpm_o) & 18'h0_00FF))
		else $error("target low byte");
	a_status_closed: assert property (
		ce_i && reg_req_i.re && reg_req_i.addr == ADDR_STATUS
		|=> reg_rdata_o[7:2] == {5'h00, $past(closed_loop_o)}) else $error("status mode");
	a_ce_freeze: assert property (
		!ce_i |=> $stable(target_rpm_o) && $stable(bypass_o)) else $error("moved while frozen");
	c_bypass: cover property ($rose(bypass_o));
	c_fall: cover property (target_rpm_o < $past(target_rpm_o));
	c_open: cover property ($fell(closed_loop_o));
endmodule
bind clst_top clst_top_chk #(.DECEL_PERIOD(DECEL_PERIOD)) chk (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .ce_i(ce_i), .speed_command_i(speed_command_i), .reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o), .target_rpm_o(target_rpm_o), .closed_loop_o(closed_loop_o),
	.bypass_o(bypass_o), .bypass_duty_o(bypass_duty_o));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import clst_pkg::*;
	localparam int LO = 102;
	localparam int HLT = 92;
	localparam int TOP = 461;
	localparam int INIT = 1500;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic slow = 1'b0;
	logic pk = 1'b0;
	logic obs = 1'b0;
	logic [9:0] goal = 10'h000;
	logic [9:0] cmd;
	clst_reg_req_t req = '0;
	logic [7:0] rdata;
	logic [17:0] tgt;
	logic cl;
	logic byp;
	logic [9:0] bd;
	logic [19:0] q[$];
	logic [19:0] e;
	logic [31:0] rs = 32'h0000_27C6;
	int bad_count = 0;
	int n_compared = 0;
	int steps[8] = '{0, 512, 2200, 3800, 5400, 7000, 8600, 10240};
	int kn = 0;
	bit fo, kr, mz;
	always #2 clk_sys_i = ~clk_sys_i;
	clst_host_model host (.clk_sys_i(clk_sys_i), .goal_i(goal), .slow_i(slow),
		.speed_command_o(cmd));
	clst_top #(.DECEL_PERIOD(16)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.speed_command_i(cmd), .reg_req_i(req), .reg_rdata_o(rdata), .target_rpm_o(tgt),
		.closed_loop_o(cl), .bypass_o(byp), .bypass_duty_o(bd));
	task automatic summarize();
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail(input logic [17:0] got, input logic [19:0] x);
		bad_count++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, x[17:0]);
	endtask
	// scoreboard: oldest note against each observed result
	always @(posedge clk_sys_i) obs <= (req.re && ce_i) || pk;
	always @(negedge clk_sys_i) begin
		if (obs && q.size() > 0) begin
			e = q.pop_front();
			n_compared++;
			case (e[19:18])
				2'd0: if ({10'h000, rdata} !== e[17:0]) fail({10'h000, rdata}, e);
				2'd1: if ({8'h00, bd} !== e[17:0]) fail({8'h00, bd}, e);
				default: if (tgt !== e[17:0]) fail(tgt, e);
			endcase
		end
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic int curve(input int d);
		int x;
		x = (d < LO) ? LO : (d > TOP) ? TOP : d;
		if (kn != 0 && x > kn) return INIT + 2407 * (kn - LO) / 64 + 1000 * (x - kn) / 64;
		return INIT + 2407 * (x - LO) / 64;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		req <= '0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		q.push_back({12'h000, x});
		req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i);
		req <= '0;
		@(posedge clk_sys_i);
	endtask
	task automatic pk2(input logic [1:0] s, input int a, input int b, input bit two);
		q.push_back({s, a[17:0]});
		if (two) q.push_back({s, b[17:0]});
		pk <= 1'b1;
		repeat (two ? 2 : 1) @(posedge clk_sys_i);
		pk <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic go(input int c);
		goal <= c[9:0];
		repeat (2) @(posedge clk_sys_i);
		for (int i = 0; i < 600 && cmd !== goal; i++) @(posedge clk_sys_i);
		if (cmd !== goal) begin
			bad_count++;
			summarize();
		end
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic opt();
		wr(ADDR_HALT, {kr, 7'h2E});
		wr(ADDR_GRAD_LO, {6'h27, fo, mz});
	endtask
	task automatic low(input int c, input bit fall);
		bit mx;
		int t;
		mx = mz && (c == 0 || (kr && c <= HLT));
		t = mx ? curve(TOP) : kr ? INIT : (c <= HLT || !fall) ? 0 : INIT;
		go(c);
		pk2(2'd1, (mx && fo) ? 512 : 0, 0, 0);
		if (!(mx && fo)) pk2(2'd2, t, 0, 0);
	endtask
	initial begin
		#400000;
		bad_count++;
		summarize();
	end
	initial begin
		logic [31:0] r;
		int c, h, x1, x2;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(ADDR_LAUNCH, 8'h00);
		rd(8'h30, 8'h00);
		wr(ADDR_LAUNCH, 8'h66);
		wr(ADDR_TOP, 8'hCC);
		wr(ADDR_INIT_HI, 8'h5D);
		wr(ADDR_INIT_LO, 8'hC9);
		wr(ADDR_GRAD_HI, 8'h25);
		opt();
		wr(ADDR_TGT_L, 8'h55);
		rd(ADDR_LAUNCH, 8'h66);
		rd(ADDR_HALT, 8'h2E);
		rd(ADDR_TOP, 8'hCC);
		rd(ADDR_INIT_LO, 8'hC9);
		rd(ADDR_GRAD_LO, 8'h9C);
		rd(ADDR_TGT_L, 8'h00);
		rd(ADDR_STATUS, 8'h04);
		$display("registers done");
		wr(ADDR_GRAD2_HI, 8'h0F);
		wr(ADDR_GRAD2_LO, 8'hA0);
		for (int k = 0; k < 2; k++) begin
			kn = 256 * k;
			wr(ADDR_KNEE, k[0] ? 8'h80 : 8'h00);
			for (int i = 0; i < 10; i++) begin
				r = xs();
				c = LO + 1 + int'(r[31:8] % 410);
				slow <= r[0];
				go(c);
				pk2(2'd2, curve(c), 0, 0);
			end
			go(512);
			pk2(2'd2, curve(TOP), 0, 0);
			ce_i <= 1'b0;
			go(LO + 1);
			pk2(2'd2, curve(TOP), 0, 0);
			ce_i <= 1'b1;
		end
		slow <= 1'b0;
		$display("curve done");
		for (int m = 0; m < 8; m++) begin
			{fo, kr, mz} = m[2:0];
			opt();
			low(0, 1'b0);
			low(HLT, 1'b0);
			low(HLT + 1, 1'b0);
			go(LO + 20);
			low(HLT + 1, 1'b1);
		end
		$display("low command done");
		{fo, kr, mz} = 3'b100;
		opt();
		go(TOP);
		pk2(2'd1, TOP, 0, 0);
		go(TOP - 20);
		pk2(2'd1, TOP - 20, 0, 0);
		go(TOP - 21);
		pk2(2'd1, 0, 0, 0);
		pk2(2'd2, curve(TOP - 21), 0, 0);
		$display("full open done");
		{fo, kr, mz} = 3'b000;
		opt();
		h = curve(512);
		for (int k = 1; k < 8; k++) begin
			wr(ADDR_DECEL, {k[2:0], 5'h00});
			go(512);
			pk2(2'd2, h, 0, 0);
			goal <= 10'h067;
			x1 = (h - steps[k] > curve(LO + 1)) ? h - steps[k] : curve(LO + 1);
			x2 = (x1 - steps[k] > curve(LO + 1)) ? x1 - steps[k] : curve(LO + 1);
			c = 0;
			while (c < 40 && tgt === h[17:0]) begin
				@(negedge clk_sys_i);
				c++;
			end
			if (c == 40) begin
				bad_count++;
				summarize();
			end
			repeat (14) @(posedge clk_sys_i);
			pk2(2'd2, x1, x2, 1);
		end
		wr(ADDR_DECEL, 8'h00);
		pk2(2'd2, curve(LO + 1), 0, 0);
		$display("decrease limit done");
		{fo, kr, mz} = 3'b100;
		opt();
		go(512);
		wr(ADDR_GRAD2_LO, 8'hA1);
		repeat (2) @(posedge clk_sys_i);
		pk2(2'd1, 0, 0, 0);
		pk2(2'd2, 0, 0, 0);
		n_compared++;
		if (cl !== 1'b0) fail({17'h0_0000, cl}, 20'h0_0000);
		rd(ADDR_STATUS, 8'h00);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(ADDR_GRAD2_LO, 8'h00);
		repeat (2) @(posedge clk_sys_i);
		$display("open loop done");
		summarize();
	end
endmodule

// ===== rtl/clst_decel_limiter.sv
`timescale 1ns/1ps
module clst_decel_limiter #(
	parameter int unsigned PERIOD = clst_pkg::DECEL_PERIOD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [clst_pkg::TGT_W-1:0] req_i,
	input wire logic [2:0] code_i,
	output logic [clst_pkg::TGT_W-1:0] out_o
);
	import clst_pkg::*;

	clst_lim_t s;
	clst_lim_t next_s;
	logic tick;
	logic [TGT_W-1:0] step;

	assign tick = (s.cnt == CNT_W'(PERIOD - 1));
	assign step = decel_step(code_i);
	assign out_o = s.out;

	always_comb begin
		next_s = s;
		next_s.cnt = tick ? '0 : s.cnt + 1'b1;
		if (code_i == DECEL_NONE || req_i >= s.out) begin
			next_s.out = req_i;
		end else if (tick) begin
			if (s.out - req_i > step) begin
				next_s.out = s.out - step;
			end else begin
				next_s.out = req_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s <= LIM_RST;
		end else if (ce_i) begin
			s <= next_s;
		end
	end
endmodule

// ===== rtl/clst_pkg.sv
package clst_pkg;
	localparam int CLK_MHZ = 250;
	localparam int CMD_W = 10;
	localparam int TGT_W = 18;
	localparam int GRAD_W = 14;
	localparam int RPM_W = 12;
	localparam int PROD_W = 24;
	localparam int CNT_W = 20;
	localparam int SLOPE_SHIFT = 6;
	localparam int HALT_MSB = 6;
	localparam int HYS_MSB = 3;
	localparam int KEEP_RUNNING_OPTION_BIT = 7;
	localparam int FULL_OPEN_BIT = 1;
	localparam int MAX_ZERO_BIT = 0;
	localparam int MODE_BIT = 0;
	localparam int DECEL_LSB = 5;
	localparam int DECEL_MSB = 7;
	// decrease step interval, microseconds
	localparam int DECEL_PERIOD_US = 1000;
	localparam int DECEL_PERIOD_CYC = DECEL_PERIOD_US * CLK_MHZ;
	localparam logic [CMD_W-1:0] CMD_FULL = 10'h200;
	localparam logic [CMD_W-1:0] MAX_BIAS = 10'h101;
	localparam logic [4:0] HYS_ONE = 5'h01;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] ADDR_HALT = 8'h02;
	localparam logic [7:0] ADDR_LAUNCH = 8'h03;
	localparam logic [7:0] ADDR_KNEE = 8'h04;
	localparam logic [7:0] ADDR_TOP = 8'h05;
	localparam logic [7:0] ADDR_INIT_HI = 8'h06;
	localparam logic [7:0] ADDR_INIT_LO = 8'h07;
	localparam logic [7:0] ADDR_GRAD_HI = 8'h08;
	localparam logic [7:0] ADDR_GRAD_LO = 8'h09;
	localparam logic [7:0] ADDR_GRAD2_HI = 8'h0A;
	localparam logic [7:0] ADDR_GRAD2_LO = 8'h0B;
	localparam logic [7:0] ADDR_DECEL = 8'h12;
	localparam logic [7:0] ADDR_TGT_U = 8'h20;
	localparam logic [7:0] ADDR_TGT_M = 8'h21;
	localparam logic [7:0] ADDR_TGT_L = 8'h22;
	localparam logic [7:0] ADDR_STATUS = 8'h23;
	localparam logic [2:0] DECEL_NONE = 3'h0;
	localparam logic [TGT_W-1:0] DECEL_512 = 18'h0_0200;
	localparam logic [TGT_W-1:0] DECEL_2200 = 18'h0_0898;
	localparam logic [TGT_W-1:0] DECEL_3800 = 18'h0_0ED8;
	localparam logic [TGT_W-1:0] DECEL_5400 = 18'h0_1518;
	localparam logic [TGT_W-1:0] DECEL_7000 = 18'h0_1B58;
	localparam logic [TGT_W-1:0] DECEL_8600 = 18'h0_2198;
	localparam logic [TGT_W-1:0] DECEL_10240 = 18'h0_2800;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FULL = 2'b10
	} clst_mode_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} clst_reg_req_t;

	typedef struct packed {
		logic [7:0] halt;
		logic [7:0] launch;
		logic [7:0] knee;
		logic [7:0] top;
		logic [7:0] init_hi;
		logic [7:0] init_lo;
		logic [7:0] grad_hi;
		logic [7:0] grad_lo;
		logic [7:0] grad2_hi;
		logic [7:0] grad2_lo;
		logic [7:0] decel;
	} clst_cfg_t;

	typedef struct packed {
		clst_cfg_t cfg;
		clst_mode_t mode;
		logic closed;
		logic bypass;
		logic [CMD_W-1:0] bypass_duty;
		logic [TGT_W-1:0] req;
		logic [7:0] rdata;
	} clst_state_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [TGT_W-1:0] out;
	} clst_lim_t;

	localparam clst_state_t STATE_RST = '0;
	localparam clst_lim_t LIM_RST = '0;

	function automatic logic [TGT_W-1:0] decel_step(input logic [2:0] code);
		case (code)
			3'h1: return DECEL_512;
			3'h2: return DECEL_2200;
			3'h3: return DECEL_3800;
			3'h4: return DECEL_5400;
			3'h5: return DECEL_7000;
			3'h6: return DECEL_8600;
			default: return DECEL_10240;
		endcase
	endfunction
endpackage

// ===== rtl/clst_top.sv
`timescale 1ns/1ps
// Contract
// - launch threshold is 8 bits, value over 512 of full command
// - halt threshold is 7 bits, value times two over 512
// - top threshold is 8 bits, value plus 257 over 512
// - initial speed 12 bits: high byte, then top nibble of next
// - first gradient 14 bits, 0.08 rpm per percent per count
// - no stored maximum; maximum is the curve value at top threshold
// - top hysteresis 4 bits, (value+1) times 0.4 percent
// - full open passes duty at top; resumes below top minus hysteresis
// - without keep running: zero at halt, rise 0, fall initial
// - keep running gives initial speed up to launch threshold
// - max at zero gives maximum at zero, with keep running to halt
// - full open turns every low-command maximum into 100 percent duty
// - knee point 8 bits, value times two over 512; zero disables
// - above knee a second gradient continues from knee target
// - knee works together with full open and low-command options
// - only decreases of target are limited, stepped gradually
// - 3-bit decrease limit code selects step from none to 10240
// - command is 10-bit scale, 512 is full; thresholds compare to it
// - mode bit clear is closed loop; curve applies only then
module clst_top #(
	parameter int unsigned DECEL_PERIOD = clst_pkg::DECEL_PERIOD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [clst_pkg::CMD_W-1:0] speed_command_i,
	input wire clst_pkg::clst_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic [clst_pkg::TGT_W-1:0] target_rpm_o,
	output logic closed_loop_o,
	output logic bypass_o,
	output logic [clst_pkg::CMD_W-1:0] bypass_duty_o
);
	import clst_pkg::*;

	clst_state_t st;
	clst_state_t next_st;
	logic [TGT_W-1:0] limited;
	logic [CMD_W-1:0] cmd;
	logic [CMD_W-1:0] launch_d;
	logic [CMD_W-1:0] halt_d;
	logic [CMD_W-1:0] top_d;
	logic [CMD_W-1:0] knee_d;
	logic [CMD_W-1:0] hys_d;
	logic [CMD_W-1:0] exit_d;
	logic [CMD_W-1:0] cmd_cl;
	logic [RPM_W-1:0] init_rpm;
	logic [TGT_W-1:0] init_t;
	logic [GRAD_W-1:0] grad1;
	logic [GRAD_W-1:0] grad2;
	logic keep_running_option;
	logic full_open_option;
	logic max_at_zero_option;
	logic control_mode_select;
	logic [TGT_W-1:0] run_tgt;
	logic [TGT_W-1:0] max_tgt;
	logic cmd_zero;
	logic at_or_below_halt;
	logic at_or_below_launch;
	logic above_launch;
	logic at_or_above_top;
	logic below_exit;
	logic max_case;

	function automatic logic [TGT_W-1:0] seg(
		input logic [TGT_W-1:0] base,
		input logic [GRAD_W-1:0] g,
		input logic [CMD_W-1:0] delta
	);
		logic [PROD_W-1:0] p;
		p = PROD_W'(g) * PROD_W'(delta);
		return base + TGT_W'(p >> SLOPE_SHIFT);
	endfunction

	function automatic logic [TGT_W-1:0] curve(
		input logic [CMD_W-1:0] duty,
		input logic [CMD_W-1:0] lo,
		input logic [CMD_W-1:0] kn,
		input logic [TGT_W-1:0] init,
		input logic [GRAD_W-1:0] g1,
		input logic [GRAD_W-1:0] g2
	);
		logic [CMD_W-1:0] d;
		logic [TGT_W-1:0] at_knee;
		logic knee_on;
		d = (duty < lo) ? lo : duty;
		knee_on = (kn != '0) && (kn > lo);
		at_knee = seg(init, g1, kn - lo);
		if (knee_on && d > kn) begin
			return seg(at_knee, g2, d - kn);
		end else begin
			return seg(init, g1, d - lo);
		end
	endfunction

	// command in 1/512 steps, same clock as capture logic
	assign cmd = speed_command_i;

	assign launch_d = CMD_W'(st.cfg.launch);
	assign halt_d = CMD_W'({st.cfg.halt[HALT_MSB:0], 1'b0});
	assign top_d = CMD_W'(st.cfg.top) + MAX_BIAS;
	assign knee_d = CMD_W'({st.cfg.knee, 1'b0});
	assign hys_d = CMD_W'({5'(st.cfg.init_lo[HYS_MSB:0]) + HYS_ONE, 1'b0});
	assign exit_d = top_d - hys_d;

	assign init_rpm = {st.cfg.init_hi, st.cfg.init_lo[7:4]};
	assign init_t = TGT_W'(init_rpm);
	assign grad1 = {st.cfg.grad_hi, st.cfg.grad_lo[7:2]};
	assign grad2 = {st.cfg.grad2_hi, st.cfg.grad2_lo[7:2]};

	assign keep_running_option = st.cfg.halt[KEEP_RUNNING_OPTION_BIT];
	assign full_open_option = st.cfg.grad_lo[FULL_OPEN_BIT];
	assign max_at_zero_option = st.cfg.grad_lo[MAX_ZERO_BIT];
	assign control_mode_select = st.cfg.grad2_lo[MODE_BIT];

	// all comparisons on the 512 scale
	assign cmd_zero = (cmd == '0);
	assign at_or_below_halt = (cmd <= halt_d);
	assign at_or_below_launch = (cmd <= launch_d);
	assign above_launch = !at_or_below_launch;
	assign at_or_above_top = (cmd >= top_d);
	assign below_exit = (cmd < exit_d);

	assign cmd_cl = at_or_above_top ? top_d : cmd;
	assign run_tgt = curve(cmd_cl, launch_d, knee_d, init_t, grad1, grad2);
	assign max_tgt = curve(top_d, launch_d, knee_d, init_t, grad1, grad2);

	assign max_case = max_at_zero_option &&
		(cmd_zero || (keep_running_option && at_or_below_halt));

	always_comb begin
		next_st = st;

		// register writes at their byte offsets
		if (reg_req_i.we) begin
			if (reg_req_i.addr == ADDR_HALT) begin
				next_st.cfg.halt = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_LAUNCH) begin
				next_st.cfg.launch = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_KNEE) begin
				next_st.cfg.knee = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_TOP) begin
				next_st.cfg.top = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_INIT_HI) begin
				next_st.cfg.init_hi = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_INIT_LO) begin
				next_st.cfg.init_lo = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_GRAD_HI) begin
				next_st.cfg.grad_hi = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_GRAD_LO) begin
				next_st.cfg.grad_lo = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_GRAD2_HI) begin
				next_st.cfg.grad2_hi = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_GRAD2_LO) begin
				next_st.cfg.grad2_lo = reg_req_i.wdata;
			end else if (reg_req_i.addr == ADDR_DECEL) begin
				next_st.cfg.decel = reg_req_i.wdata;
			end
		end

		// register reads, unmapped offsets give zero
		if (reg_req_i.re) begin
			if (reg_req_i.addr == ADDR_HALT) begin
				next_st.rdata = st.cfg.halt;
			end else if (reg_req_i.addr == ADDR_LAUNCH) begin
				next_st.rdata = st.cfg.launch;
			end else if (reg_req_i.addr == ADDR_KNEE) begin
				next_st.rdata = st.cfg.knee;
			end else if (reg_req_i.addr == ADDR_TOP) begin
				next_st.rdata = st.cfg.top;
			end else if (reg_req_i.addr == ADDR_INIT_HI) begin
				next_st.rdata = st.cfg.init_hi;
			end else if (reg_req_i.addr == ADDR_INIT_LO) begin
				next_st.rdata = st.cfg.init_lo;
			end else if (reg_req_i.addr == ADDR_GRAD_HI) begin
				next_st.rdata = st.cfg.grad_hi;
			end else if (reg_req_i.addr == ADDR_GRAD_LO) begin
				next_st.rdata = st.cfg.grad_lo;
			end else if (reg_req_i.addr == ADDR_GRAD2_HI) begin
				next_st.rdata = st.cfg.grad2_hi;
			end else if (reg_req_i.addr == ADDR_GRAD2_LO) begin
				next_st.rdata = st.cfg.grad2_lo;
			end else if (reg_req_i.addr == ADDR_DECEL) begin
				next_st.rdata = st.cfg.decel;
			end else if (reg_req_i.addr == ADDR_TGT_U) begin
				next_st.rdata = 8'(limited[TGT_W-1:16]);
			end else if (reg_req_i.addr == ADDR_TGT_M) begin
				next_st.rdata = limited[15:8];
			end else if (reg_req_i.addr == ADDR_TGT_L) begin
				next_st.rdata = limited[7:0];
			end else if (reg_req_i.addr == ADDR_STATUS) begin
				next_st.rdata = {5'h00, st.closed, st.mode};
			end else begin
				next_st.rdata = REG_RST;
			end
		end

		// mode tracking: rise/fall memory and full-open latch
		case (st.mode)
			ST_IDLE: begin
				if (control_mode_select) begin
					next_st.mode = ST_IDLE;
				end else if (full_open_option && at_or_above_top) begin
					next_st.mode = ST_FULL;
				end else if (above_launch) begin
					next_st.mode = ST_RUN;
				end
			end
			ST_RUN: begin
				if (control_mode_select) begin
					next_st.mode = ST_IDLE;
				end else if (full_open_option && at_or_above_top) begin
					next_st.mode = ST_FULL;
				end else if (!keep_running_option && at_or_below_halt) begin
					next_st.mode = ST_IDLE;
				end
			end
			ST_FULL: begin
				if (control_mode_select) begin
					next_st.mode = ST_IDLE;
				end else if (!full_open_option || below_exit) begin
					next_st.mode = ST_RUN;
				end
			end
			default: begin
				next_st.mode = ST_IDLE;
			end
		endcase

		next_st.closed = !control_mode_select;
		next_st.bypass = 1'b0;
		next_st.bypass_duty = '0;

		if (control_mode_select) begin
			next_st.req = '0;
		end else if (st.mode == ST_FULL) begin
			next_st.bypass = 1'b1;
			next_st.bypass_duty = cmd;
		end else if (at_or_below_launch) begin
			if (max_case) begin
				if (full_open_option) begin
					next_st.bypass = 1'b1;
					next_st.bypass_duty = CMD_FULL;
				end else begin
					next_st.req = max_tgt;
				end
			end else if (keep_running_option) begin
				next_st.req = init_t;
			end else if (at_or_below_halt) begin
				next_st.req = '0;
			end else if (st.mode == ST_RUN) begin
				next_st.req = init_t;
			end else begin
				next_st.req = '0;
			end
		end else begin
			next_st.req = run_tgt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st <= STATE_RST;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	clst_decel_limiter #(
		.PERIOD(DECEL_PERIOD)
	) u_limiter (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.req_i(st.req),
		.code_i(st.cfg.decel[DECEL_MSB:DECEL_LSB]),
		.out_o(limited)
	);

	assign target_rpm_o = limited;
	assign reg_rdata_o = st.rdata;
	assign closed_loop_o = st.closed;
	assign bypass_o = st.bypass;
	assign bypass_duty_o = st.bypass_duty;
endmodule
